/* src/ssfsd_regs.svh */
// Constants for the subtract, swap and FPU register store datapath
`ifndef SSFSD_REGS_SVH
`define SSFSD_REGS_SVH

// ****************************************
// Opcode fields
// ****************************************
`define SSFSD_TOP_MOVE       4'h0
`define SSFSD_TOP_PUSH       4'h4
`define SSFSD_TOP_ARITH      4'h3
`define SSFSD_TOP_SWAP       4'h6
`define SSFSD_LOW_SYSREG_GPR 4'ha
`define SSFSD_LOW_SYSREG_MEM 4'h2
`define SSFSD_MID_XFER       4'h5
`define SSFSD_MID_CSR        4'h6
`define SSFSD_LOW_DIFF       4'h8
`define SSFSD_LOW_DIFF_BRW   4'ha
`define SSFSD_LOW_DIFF_UNF   4'hb
`define SSFSD_LOW_BYTE_SWAP  4'h8
`define SSFSD_LOW_HALF_SWAP  4'h9

// ****************************************
// Datapath values
// ****************************************
`define SSFSD_CSR_STORE_MASK 32'h003fffff
`define SSFSD_PREDEC_STEP    32'h00000004
`define SSFSD_WORD_ALIGN_LSB 2'h0

// ****************************************
// Reset values
// ****************************************
`define SSFSD_RST_READY      1'h1
`define SSFSD_RST_T          1'h0
`define SSFSD_RST_WORD       32'h00000000
`define SSFSD_RST_GPR_IDX    4'h0

`endif

/* src/ssfsd_pkg.sv */
// Types shared by the subtract, swap and FPU register store datapath
package ssfsd_pkg;

  typedef enum logic [3:0] {
    SSFSD_OP_NONE          = 4'b0000,
    SSFSD_OP_XFER_TO_GPR   = 4'b0001,
    SSFSD_OP_CSR_TO_GPR    = 4'b0010,
    SSFSD_OP_PUSH_XFER     = 4'b0011,
    SSFSD_OP_PUSH_CSR      = 4'b0100,
    SSFSD_OP_DIFF          = 4'b0101,
    SSFSD_OP_DIFF_BORROW   = 4'b0110,
    SSFSD_OP_DIFF_UNDERFLW = 4'b0111,
    SSFSD_OP_BYTE_SWAP     = 4'b1000,
    SSFSD_OP_HALF_SWAP     = 4'b1001
  } ssfsd_op_t;

  typedef enum logic [1:0] {
    SSFSD_EXC_NONE      = 2'b00,
    SSFSD_EXC_TLB_MISS  = 2'b01,
    SSFSD_EXC_TLB_PROT  = 2'b10,
    SSFSD_EXC_ADDR_ERR  = 2'b11
  } ssfsd_exc_t;

  typedef enum logic [1:0] {
    SSFSD_ST_IDLE  = 2'b00,
    SSFSD_ST_STORE = 2'b01
  } ssfsd_state_t;

  typedef struct packed {
    ssfsd_state_t state;
    logic         issueReady;
    logic         doneValid;
    logic         illegal;
    logic         excValid;
    ssfsd_exc_t   excCode;
    logic         memWrValid;
    logic [31:0]  memWrAddr;
    logic [31:0]  memWrData;
    logic [3:0]   pendGpr;
    logic         tFlag;
    logic [31:0]  dbgData;
  } ssfsd_core_t;

endpackage : ssfsd_pkg

/* src/ssfsd_alu.sv */
// Combinational result logic for the subtract, swap and FPU store group
`timescale 1ns/1ps
`include "ssfsd_regs.svh"

module ssfsd_alu
  import ssfsd_pkg::*;
(
  input  wire ssfsd_op_t   op,
  input  wire logic [31:0] dstVal,
  input  wire logic [31:0] srcVal,
  input  wire logic        tIn,
  input  wire logic [31:0] fpuTransferReg,
  input  wire logic [31:0] fpuControlStatusReg,
  output logic [31:0]      result,
  output logic [31:0]      storeData,
  output logic             tOut,
  output logic             tWrite
);

  logic [31:0] diff;
  logic [31:0] diffT;
  logic [31:0] csrMasked;

  assign diff      = dstVal - srcVal;
  assign diffT     = diff - {31'h0, tIn};
  assign csrMasked = fpuControlStatusReg & `SSFSD_CSR_STORE_MASK;

  always_comb begin
    result    = dstVal;
    storeData = fpuTransferReg;
    tOut      = tIn;
    tWrite    = 1'b0;
    case (op)
      SSFSD_OP_XFER_TO_GPR: result = fpuTransferReg;
      SSFSD_OP_CSR_TO_GPR:  result = csrMasked;
      SSFSD_OP_PUSH_XFER: begin
        result    = dstVal - `SSFSD_PREDEC_STEP;
        storeData = fpuTransferReg;
      end
      SSFSD_OP_PUSH_CSR: begin
        result    = dstVal - `SSFSD_PREDEC_STEP;
        storeData = csrMasked;
      end
      SSFSD_OP_DIFF: result = diff;
      SSFSD_OP_DIFF_BORROW: begin
        result = diffT;
        tOut   = (dstVal < diff) | (diff < diffT);
        tWrite = 1'b1;
      end
      SSFSD_OP_DIFF_UNDERFLW: begin
        result = diff;
        tOut   = (dstVal[31] != srcVal[31]) & (diff[31] != dstVal[31]);
        tWrite = 1'b1;
      end
      SSFSD_OP_BYTE_SWAP: result = {srcVal[31:16], srcVal[7:0], srcVal[15:8]};
      SSFSD_OP_HALF_SWAP: result = {srcVal[15:0], srcVal[31:16]};
      default: result = dstVal;
    endcase
  end

endmodule : ssfsd_alu

/* src/ssfsd_exec.sv */
// Execute stage for FPU register stores, subtractions and swaps
`timescale 1ns/1ps
`include "ssfsd_regs.svh"

module ssfsd_exec
  import ssfsd_pkg::*;
#(
  parameter int GPR_COUNT = 16
)
(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        issueValid,
  input  wire logic [15:0] issueInstr,
  output logic             issueReady_q,
  output logic             doneValid_q,
  output logic             illegalInstr_q,
  output logic             excValid_q,
  output ssfsd_exc_t       excCode_q,
  input  wire logic [31:0] fpuTransferReg,
  input  wire logic [31:0] fpuControlStatusReg,
  output logic             memWrValid_q,
  output logic [31:0]      memWrAddr_q,
  output logic [31:0]      memWrData_q,
  input  wire logic        memWrReady,
  input  wire ssfsd_exc_t  memWrResp,
  output logic             tFlag_q,
  input  wire logic        tLoadValid,
  input  wire logic        tLoadValue,
  input  wire logic        gprLoadValid,
  input  wire logic [3:0]  gprLoadIdx,
  input  wire logic [31:0] gprLoadData,
  input  wire logic [3:0]  dbgGprIdx,
  output logic [31:0]      dbgGprData_q
);

  // ****************************************
  // Reset image of the control state
  // ****************************************
  localparam ssfsd_core_t CORE_RST = '{
    state:      SSFSD_ST_IDLE,
    issueReady: `SSFSD_RST_READY,
    doneValid:  1'h0,
    illegal:    1'h0,
    excValid:   1'h0,
    excCode:    SSFSD_EXC_NONE,
    memWrValid: 1'h0,
    memWrAddr:  `SSFSD_RST_WORD,
    memWrData:  `SSFSD_RST_WORD,
    pendGpr:    `SSFSD_RST_GPR_IDX,
    tFlag:      `SSFSD_RST_T,
    dbgData:    `SSFSD_RST_WORD
  };

  // ****************************************
  // Decode
  // ****************************************
  function automatic ssfsd_op_t decodeOp(input logic [15:0] instr);
    ssfsd_op_t op;
    op = SSFSD_OP_NONE;
    if (instr[15:12] == `SSFSD_TOP_MOVE && instr[3:0] == `SSFSD_LOW_SYSREG_GPR) begin
      if (instr[7:4] == `SSFSD_MID_XFER) begin
        op = SSFSD_OP_XFER_TO_GPR;
      end else if (instr[7:4] == `SSFSD_MID_CSR) begin
        op = SSFSD_OP_CSR_TO_GPR;
      end
    end else if (instr[15:12] == `SSFSD_TOP_PUSH && instr[3:0] == `SSFSD_LOW_SYSREG_MEM) begin
      if (instr[7:4] == `SSFSD_MID_XFER) begin
        op = SSFSD_OP_PUSH_XFER;
      end else if (instr[7:4] == `SSFSD_MID_CSR) begin
        op = SSFSD_OP_PUSH_CSR;
      end
    end else if (instr[15:12] == `SSFSD_TOP_ARITH) begin
      if (instr[3:0] == `SSFSD_LOW_DIFF) begin
        op = SSFSD_OP_DIFF;
      end else if (instr[3:0] == `SSFSD_LOW_DIFF_BRW) begin
        op = SSFSD_OP_DIFF_BORROW;
      end else if (instr[3:0] == `SSFSD_LOW_DIFF_UNF) begin
        op = SSFSD_OP_DIFF_UNDERFLW;
      end
    end else if (instr[15:12] == `SSFSD_TOP_SWAP) begin
      if (instr[3:0] == `SSFSD_LOW_BYTE_SWAP) begin
        op = SSFSD_OP_BYTE_SWAP;
      end else if (instr[3:0] == `SSFSD_LOW_HALF_SWAP) begin
        op = SSFSD_OP_HALF_SWAP;
      end
    end
    return op;
  endfunction : decodeOp

  function automatic logic isPush(input ssfsd_op_t op);
    return (op == SSFSD_OP_PUSH_XFER) || (op == SSFSD_OP_PUSH_CSR);
  endfunction : isPush

  // ****************************************
  // State and register file
  // ****************************************
  ssfsd_core_t core_q;
  ssfsd_core_t core_d;

  logic [31:0] gprFile [GPR_COUNT];

  ssfsd_op_t   curOp;
  logic [3:0]  dstIdx;
  logic [3:0]  srcIdx;
  logic [31:0] dstVal;
  logic [31:0] srcVal;
  logic [31:0] aluResult;
  logic [31:0] aluStore;
  logic        aluT;
  logic        aluTWrite;
  logic        issueTaken;
  logic        gprWe;
  logic [3:0]  gprWa;
  logic [31:0] gprWd;

  assign curOp      = decodeOp(issueInstr);
  assign dstIdx     = issueInstr[11:8];
  assign srcIdx     = issueInstr[7:4];
  assign issueTaken = issueValid && core_q.issueReady;

  // Operands are sampled from the array before the edge that writes it
  assign dstVal = gprFile[dstIdx];
  assign srcVal = gprFile[srcIdx];

  ssfsd_alu u_alu (
    .op                  (curOp),
    .dstVal              (dstVal),
    .srcVal              (srcVal),
    .tIn                 (core_q.tFlag),
    .fpuTransferReg      (fpuTransferReg),
    .fpuControlStatusReg (fpuControlStatusReg),
    .result              (aluResult),
    .storeData           (aluStore),
    .tOut                (aluT),
    .tWrite              (aluTWrite)
  );

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    core_d           = core_q;
    core_d.doneValid = 1'b0;
    core_d.illegal   = 1'b0;
    core_d.excValid  = 1'b0;
    core_d.dbgData   = gprFile[dbgGprIdx];
    gprWe            = 1'b0;
    gprWa            = dstIdx;
    gprWd            = aluResult;

    case (core_q.state)
      SSFSD_ST_IDLE: begin
        if (issueTaken) begin
          if (curOp == SSFSD_OP_NONE) begin
            core_d.doneValid = 1'b1;
            core_d.illegal   = 1'b1;
          end else if (isPush(curOp)) begin
            if (aluResult[1:0] != `SSFSD_WORD_ALIGN_LSB) begin
              // Misaligned target never reaches memory and leaves dest_gpr intact
              core_d.excValid  = 1'b1;
              core_d.excCode   = SSFSD_EXC_ADDR_ERR;
              core_d.doneValid = 1'b1;
            end else begin
              core_d.memWrValid = 1'b1;
              core_d.memWrAddr  = aluResult;
              core_d.memWrData  = aluStore;
              core_d.pendGpr    = dstIdx;
              core_d.issueReady = 1'b0;
              core_d.state      = SSFSD_ST_STORE;
            end
          end else begin
            gprWe            = 1'b1;
            core_d.doneValid = 1'b1;
            if (aluTWrite) begin
              core_d.tFlag = aluT;
            end
          end
        end else if (tLoadValid) begin
          core_d.tFlag = tLoadValue;
        end
      end

      SSFSD_ST_STORE: begin
        if (memWrReady) begin
          core_d.memWrValid = 1'b0;
          core_d.doneValid  = 1'b1;
          core_d.issueReady = 1'b1;
          core_d.state      = SSFSD_ST_IDLE;
          if (memWrResp == SSFSD_EXC_NONE) begin
            // Pointer commits only once the store is accepted, keeping faults restartable
            gprWe = 1'b1;
            gprWa = core_q.pendGpr;
            gprWd = core_q.memWrAddr;
          end else begin
            core_d.excValid = 1'b1;
            core_d.excCode  = memWrResp;
          end
        end else if (tLoadValid) begin
          core_d.tFlag = tLoadValue;
        end
      end

      default: begin
        core_d = CORE_RST;
      end
    endcase
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      core_q <= CORE_RST;
    end else begin
      core_q <= core_d;
    end
  end

  // Datapath writes win over the side load port in the same cycle
  always_ff @(posedge mclk) begin
    if (gprWe) begin
      gprFile[gprWa] <= gprWd;
    end else if (gprLoadValid) begin
      gprFile[gprLoadIdx] <= gprLoadData;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign issueReady_q   = core_q.issueReady;
  assign doneValid_q    = core_q.doneValid;
  assign illegalInstr_q = core_q.illegal;
  assign excValid_q     = core_q.excValid;
  assign excCode_q      = core_q.excCode;
  assign memWrValid_q   = core_q.memWrValid;
  assign memWrAddr_q    = core_q.memWrAddr;
  assign memWrData_q    = core_q.memWrData;
  assign tFlag_q        = core_q.tFlag;
  assign dbgGprData_q   = core_q.dbgData;

endmodule : ssfsd_exec

/* test/ssfsd_exec_assertions.sv */
// Checker for the FPU store, subtract and swap execute stage
`timescale 1ns/1ps
module ssfsd_exec_chk
  import ssfsd_pkg::*;
(
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic        issueValid,
  input wire logic [15:0] issueInstr,
  input wire logic        issueReady_q,
  input wire logic        doneValid_q,
  input wire logic        excValid_q,
  input wire ssfsd_exc_t  excCode_q,
  input wire logic [31:0] fpuTransferReg,
  input wire logic [31:0] fpuControlStatusReg,
  input wire logic        memWrValid_q,
  input wire logic [31:0] memWrAddr_q,
  input wire logic [31:0] memWrData_q,
  input wire logic        memWrReady,
  input wire ssfsd_exc_t  memWrResp,
  input wire logic        tFlag_q
);
  logic        take, push, plain;
  logic [15:0] lastInstr_q;
  assign take = issueValid && issueReady_q;
  assign push = issueInstr[15:12] == 4'h4 && issueInstr[7:0] inside {8'h52, 8'h62};
  assign plain = issueInstr[15:12] == 4'h3 && issueInstr[3:0] == 4'h8 ||
    issueInstr[15:12] == 4'h6 && issueInstr[3:1] == 3'h4 ||
    issueInstr[15:12] == 4'h0 && issueInstr[7:0] inside {8'h5a, 8'h6a};
  // ********
  // Last taken word tells which system register a store must carry
  // ********
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n) lastInstr_q <= 16'h0;
    else if (take) lastInstr_q <= issueInstr;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_one_state: assert property (take && plain |=> doneValid_q && !excValid_q && issueReady_q)
    else $error("register form late");
  a_flag_kept: assert property (take && plain |=> tFlag_q == $past(tFlag_q))
    else $error("flag changed");
  a_store_start: assert property (take && push |=> memWrValid_q ^ excValid_q)
    else $error("store not started");
  a_csr_mask: assert property (memWrValid_q && lastInstr_q[7:4] == 4'h6 |->
    memWrData_q == (fpuControlStatusReg & 32'h003fffff))
    else $error("store data unmasked");
  a_xfer_data: assert property (memWrValid_q && lastInstr_q[7:4] == 4'h5 |-> memWrData_q == fpuTransferReg)
    else $error("store data wrong");
  a_addr_aligned: assert property (memWrValid_q |-> memWrAddr_q[1:0] == 2'h0)
    else $error("misaligned store issued");
  a_mem_hold: assert property (memWrValid_q && !memWrReady |=>
    memWrValid_q && $stable(memWrAddr_q) && $stable(memWrData_q))
    else $error("store dropped");
  a_fault_code: assert property (memWrValid_q && memWrReady && memWrResp != SSFSD_EXC_NONE |=>
    excValid_q && excCode_q == $past(memWrResp))
    else $error("fault not reported");
endmodule : ssfsd_exec_chk

bind ssfsd_exec ssfsd_exec_chk i_chk (.mclk, .rst_n, .issueValid, .issueInstr, .issueReady_q, .doneValid_q,
  .excValid_q, .excCode_q, .fpuTransferReg, .fpuControlStatusReg, .memWrValid_q, .memWrAddr_q, .memWrData_q,
  .memWrReady, .memWrResp, .tFlag_q);

/* test/ssfsd_mem_model.sv */
// Data memory path model that accepts long-word stores
`timescale 1ns/1ps
module ssfsd_mem_model
  import ssfsd_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        memWrValid,
  input  wire logic [31:0] memWrAddr,
  input  wire logic [31:0] memWrData,
  input  wire logic [2:0]  stall,
  input  wire ssfsd_exc_t  fault,
  output logic             memWrReady,
  output ssfsd_exc_t       memWrResp,
  output logic [31:0]      gotAddr,
  output logic [31:0]      gotData
);
  logic [2:0] waitCnt;
  // ********
  // Response lines churn while not ready so stale codes never look valid
  // ********
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      memWrReady <= 1'h0;
      memWrResp <= SSFSD_EXC_ADDR_ERR;
      waitCnt <= 3'h0;
      gotAddr <= 32'h0;
      gotData <= 32'h0;
    end else if (memWrReady && memWrValid) begin
      memWrReady <= 1'h0;
      memWrResp <= ssfsd_exc_t'(~fault);
      waitCnt <= 3'h0;
      gotAddr <= memWrAddr;
      gotData <= memWrData;
    end else if (memWrValid && waitCnt == stall) begin
      memWrReady <= 1'h1;
      memWrResp <= fault;
    end else begin
      waitCnt <= memWrValid ? waitCnt + 3'h1 : 3'h0;
      memWrResp <= ssfsd_exc_t'(memWrResp + 2'h1);
    end
  end
endmodule : ssfsd_mem_model

/* test/ssfsd_exec_tb_top.sv */
// Self-checking testbench for the FPU store, subtract and swap stage
`timescale 1ns/1ps
module ssfsd_exec_tb_top
  import ssfsd_pkg::*;
;
  typedef struct {
    logic [15:0] ins;
    logic [31:0] a, b;
    logic        t;
    logic [31:0] r;
    logic        et;
  } ssfsd_row_t;
  logic        mclk, rst_n, issueValid, issueReady_q, doneValid_q, illegalInstr_q, excValid_q, memWrValid_q;
  logic        memWrReady, tFlag_q, tLoadValid, tLoadValue, gprLoadValid, ex, il;
  logic [15:0] issueInstr;
  logic [3:0]  gprLoadIdx, dbgGprIdx;
  logic [2:0]  stall;
  logic [31:0] fpuTransferReg, fpuControlStatusReg, memWrAddr_q, memWrData_q, gprLoadData, dbgGprData_q;
  logic [31:0] gotAddr, gotData;
  ssfsd_exc_t  excCode_q, memWrResp, fault;
  int          failures, samples_checked;
  ssfsd_row_t  rows[11] = '{
    '{16'h3128, 32'h80000000, 32'h1, 1'h1, 32'h7fffffff, 1'h1},
    '{16'h312a, 32'h0, 32'h1, 1'h0, 32'hffffffff, 1'h1},
    '{16'h312a, 32'h3, 32'h3, 1'h1, 32'hffffffff, 1'h1},
    '{16'h312a, 32'h5, 32'h3, 1'h1, 32'h1, 1'h0},
    '{16'h312b, 32'h80000001, 32'h2, 1'h0, 32'h7fffffff, 1'h1},
    '{16'h312b, 32'h7ffffffe, 32'hfffffffe, 1'h0, 32'h80000000, 1'h1},
    '{16'h312b, 32'h5, 32'h3, 1'h1, 32'h2, 1'h0},
    '{16'h6128, 32'h0, 32'h12345678, 1'h0, 32'h12347856, 1'h0},
    '{16'h6129, 32'h0, 32'h12345678, 1'h1, 32'h56781234, 1'h1},
    '{16'h015a, 32'h0, 32'h0, 1'h1, 32'h12abcdef, 1'h1},
    '{16'h016a, 32'h0, 32'h0, 1'h0, 32'h001cba98, 1'h0}};

  ssfsd_exec #(.GPR_COUNT(16)) i_dut (.mclk, .rst_n, .issueValid, .issueInstr, .issueReady_q, .doneValid_q,
    .illegalInstr_q, .excValid_q, .excCode_q, .fpuTransferReg, .fpuControlStatusReg, .memWrValid_q,
    .memWrAddr_q, .memWrData_q, .memWrReady, .memWrResp, .tFlag_q, .tLoadValid, .tLoadValue, .gprLoadValid,
    .gprLoadIdx, .gprLoadData, .dbgGprIdx, .dbgGprData_q);
  ssfsd_mem_model i_mem (.mclk, .rst_n, .memWrValid(memWrValid_q), .memWrAddr(memWrAddr_q),
    .memWrData(memWrData_q), .stall, .fault, .memWrReady, .memWrResp, .gotAddr, .gotData);

  task automatic report_and_stop();
    if (failures == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic ld(input logic [3:0] i, input logic [31:0] d);
    @(negedge mclk);
    gprLoadValid = 1'h1;
    gprLoadIdx = i;
    gprLoadData = d;
    @(negedge mclk);
    gprLoadValid = 1'h0;
  endtask : ld
  task automatic setT(input logic v);
    @(negedge mclk);
    tLoadValid = 1'h1;
    tLoadValue = v;
    @(negedge mclk);
    tLoadValid = 1'h0;
  endtask : setT
  task automatic iss(input logic [15:0] w);
    int n;
    n = 0;
    @(negedge mclk);
    issueValid = 1'h1;
    issueInstr = w;
    @(negedge mclk);
    issueValid = 1'h0;
    while (doneValid_q !== 1'h1 && n < 40) begin
      @(negedge mclk);
      n++;
    end
    chk({31'h0, doneValid_q}, 32'h1);
    ex = excValid_q;
    il = illegalInstr_q;
  endtask : iss
  task automatic rd(input logic [3:0] i, input logic [31:0] d);
    @(negedge mclk);
    dbgGprIdx = i;
    @(negedge mclk);
    chk(dbgGprData_q, d);
  endtask : rd

  initial begin
    mclk = 1'h0;
    forever #2 mclk = ~mclk;
  end
  // Whole sequence needs well under a thousand cycles
  initial begin
    #20000;
    failures++;
    report_and_stop();
  end
  initial begin
    {rst_n, issueValid, tLoadValid, tLoadValue, gprLoadValid, issueInstr, gprLoadIdx, dbgGprIdx} = '0;
    {gprLoadData, stall} = '0;
    fault = SSFSD_EXC_NONE;
    fpuTransferReg = 32'h12abcdef;
    fpuControlStatusReg = 32'hfedcba98;
    repeat (5) @(negedge mclk);
    rst_n = 1'h1;
    chk({29'h0, issueReady_q, tFlag_q, memWrValid_q}, 32'h4);
    foreach (rows[k]) begin
      ld(4'h1, rows[k].a);
      ld(4'h2, rows[k].b);
      setT(rows[k].t);
      iss(rows[k].ins);
      rd(4'h1, rows[k].r);
      chk({31'h0, tFlag_q}, {31'h0, rows[k].et});
    end
    ld(4'h3, 32'h9);
    setT(1'h1);
    iss(16'h333a);
    rd(4'h3, 32'hffffffff);
    chk({31'h0, tFlag_q}, 32'h1);
    ld(4'h7, 32'h0c700148);
    stall = 3'h3;
    iss(16'h4762);
    chk(gotAddr, 32'h0c700144);
    chk(gotData, 32'h001cba98);
    stall = 3'h0;
    iss(16'h4752);
    chk(gotData, 32'h12abcdef);
    rd(4'h7, 32'h0c700140);
    for (int f = 1; f < 4; f++) begin
      fault = ssfsd_exc_t'(f[1:0]);
      iss(16'h4752);
      chk({30'h0, ex, excCode_q == fault}, 32'h3);
    end
    rd(4'h7, 32'h0c700140);
    fault = SSFSD_EXC_NONE;
    ld(4'h7, 32'h0c700146);
    iss(16'h4762);
    chk({30'h0, ex, excCode_q == SSFSD_EXC_ADDR_ERR}, 32'h3);
    rd(4'h7, 32'h0c700146);
    // Word beside the difference encodings must come back as illegal, no exception
    iss(16'h3129);
    chk({30'h0, il, ex}, 32'h2);
    // Mid-run reset: flag, code, store and observe registers all return to idle
    @(negedge mclk);
    rst_n = 1'h0;
    @(negedge mclk);
    chk({26'h0, issueReady_q, tFlag_q, memWrValid_q, doneValid_q, excValid_q, illegalInstr_q}, 32'h20);
    chk({30'h0, excCode_q}, 32'h0);
    chk(dbgGprData_q, 32'h0);
    chk(memWrAddr_q, 32'h0);
    rst_n = 1'h1;
    iss(16'h6179);
    rd(4'h1, 32'h01460c70);
    chk({31'h0, tFlag_q}, 32'h0);
    report_and_stop();
  end
endmodule : ssfsd_exec_tb_top
